// file: pkg/frm_pkg.sv
package frm_pkg;

  localparam int REG_W = 16;
  localparam int ADDR_W = 18;
  localparam int PAR_W = 12;
  localparam int IRQ_W = 2;

  // register indices; the byte address is four times the index
  localparam logic [15:0] IDX_CLEAR = 16'hF421;
  localparam logic [15:0] IDX_PAR_MASK = 16'hF422;
  localparam logic [15:0] IDX_SW_MASK = 16'hF423;
  localparam logic [15:0] IDX_WD_MASK = 16'hF424;
  localparam logic [15:0] IDX_FLAG = 16'hF427;
  localparam logic [15:0] IDX_CODE = 16'hF428;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hF440;
  localparam logic [15:0] IDX_IRQ_CLEAR = 16'hF441;
  localparam logic [15:0] IDX_IRQ_ENABLE = 16'hF442;

  localparam logic [ADDR_W-1:0] ADDR_CLEAR = {IDX_CLEAR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PAR_MASK = {IDX_PAR_MASK, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_SW_MASK = {IDX_SW_MASK, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_WD_MASK = {IDX_WD_MASK, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_FLAG = {IDX_FLAG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CODE = {IDX_CODE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = {IDX_IRQ_CLEAR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = {IDX_IRQ_ENABLE, 2'b00};

  // reset values
  localparam logic [PAR_W-1:0] RST_PAR_MASK = 12'h003;
  localparam logic RST_SW_MASK = 1'b0;
  localparam logic RST_WD_MASK = 1'b0;
  localparam logic RST_CLEAR = 1'b0;
  localparam logic [REG_W-1:0] RST_CODE = 16'h0000;
  localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;

  // field positions
  localparam int CLEAR_POS = 0;
  localparam int SW_MASK_POS = 0;
  localparam int WD_MASK_POS = 0;
  localparam int FLAG_POS = 0;
  localparam int CODE_SW_POS = 15;
  localparam int CODE_WD_POS = 12;
  localparam int IRQ_FIRST_POS = 0;
  localparam int IRQ_LATER_POS = 1;

  // parity mask field positions, same layout as the code bits
  localparam int POS_DMEM_B_BANK3 = 11;
  localparam int POS_DMEM_B_BANK2 = 10;
  localparam int POS_DMEM_B_BANK1 = 9;
  localparam int POS_DMEM_B_BANK0 = 8;
  localparam int POS_DMEM_A_BANK3 = 7;
  localparam int POS_DMEM_A_BANK2 = 6;
  localparam int POS_DMEM_A_BANK1 = 5;
  localparam int POS_DMEM_A_BANK0 = 4;
  localparam int POS_PROGMEM_1 = 3;
  localparam int POS_PROGMEM_0 = 2;
  localparam int POS_RATE_CONVERTER_1 = 1;
  localparam int POS_RATE_CONVERTER_0 = 0;

  // apb slave states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } frm_state_type;

  // register select, one bit per register
  typedef enum logic [9:0] {
    SEL_NONE = 10'b0000000001,
    SEL_CLEAR = 10'b0000000010,
    SEL_PAR_MASK = 10'b0000000100,
    SEL_SW_MASK = 10'b0000001000,
    SEL_WD_MASK = 10'b0000010000,
    SEL_FLAG = 10'b0000100000,
    SEL_CODE = 10'b0001000000,
    SEL_IRQ_STATUS = 10'b0010000000,
    SEL_IRQ_CLEAR = 10'b0100000000,
    SEL_IRQ_ENABLE = 10'b1000000000
  } frm_sel_type;

endpackage

// file: rtl/frm_fault_capture.sv
`timescale 1ns/1ns
module frm_fault_capture (
  input wire logic clk,
  input wire logic rst,
  input wire logic [frm_pkg::PAR_W-1:0] parity_err,
  input wire logic sw_err,
  input wire logic wd_err,
  input wire logic [frm_pkg::PAR_W-1:0] parity_mask,
  input wire logic sw_mask,
  input wire logic wd_mask,
  input wire logic clear_pulse,
  output logic fault_flag,
  output logic [frm_pkg::REG_W-1:0] fault_code,
  output logic first_event,
  output logic later_event
);

  logic [frm_pkg::REG_W-1:0] reported;
  logic any_err;
  logic take;

  // gate each source by its mask, placed at code bit positions
  always_comb begin
    reported = '0;
    reported[frm_pkg::PAR_W-1:0] = parity_err & ~parity_mask;
    reported[frm_pkg::CODE_SW_POS] = sw_err & ~sw_mask;
    reported[frm_pkg::CODE_WD_POS] = wd_err & ~wd_mask;
  end

  assign any_err = |reported;
  // an error in the clearing cycle starts a fresh fault, set beats clear
  assign take = any_err && (!fault_flag || clear_pulse);

  // sticky master flag
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_flag <= 1'b0;
    end else if (take) begin
      fault_flag <= 1'b1;
    end else if (clear_pulse) begin
      fault_flag <= 1'b0;
    end
  end

  // first-error code, frozen while the flag stands
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_code <= frm_pkg::RST_CODE;
    end else if (take) begin
      fault_code <= reported;
    end else if (clear_pulse) begin
      fault_code <= frm_pkg::RST_CODE;
    end
  end

  // event pulses for the interrupt status
  always_ff @(posedge clk) begin
    if (rst) begin
      first_event <= 1'b0;
      later_event <= 1'b0;
    end else begin
      first_event <= take;
      later_event <= any_err && fault_flag && !clear_pulse;
    end
  end

endmodule // frm_fault_capture

// file: rtl/frm_fault_report.sv
`timescale 1ns/1ns
module frm_fault_report (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [frm_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [frm_pkg::PAR_W-1:0] PARITY_ERR,
  input wire logic SW_ERR,
  input wire logic WD_ERR,
  output logic FAULT,
  output logic IRQ
);

  // bus state and the register that the address selects
  frm_pkg::frm_state_type state;
  frm_pkg::frm_sel_type sel;

  // register storage
  logic clear_bit;
  logic clear_pulse;
  logic [frm_pkg::PAR_W-1:0] parity_mask;
  logic sw_mask;
  logic wd_mask;
  logic [frm_pkg::IRQ_W-1:0] irq_status;
  logic [frm_pkg::IRQ_W-1:0] irq_enable;

  // results of the capture block
  logic fault_flag;
  logic [frm_pkg::REG_W-1:0] fault_code;
  logic first_event;
  logic later_event;

  // bus qualifiers and merged write images
  logic access;
  logic wr_fire;
  logic [frm_pkg::REG_W-1:0] wr_val_clear;
  logic [frm_pkg::REG_W-1:0] wr_val_par;
  logic [frm_pkg::REG_W-1:0] wr_val_sw;
  logic [frm_pkg::REG_W-1:0] wr_val_wd;
  logic [frm_pkg::REG_W-1:0] wr_val_irq;

  // read value and interrupt next values
  logic [frm_pkg::REG_W-1:0] rd_val;
  logic [frm_pkg::IRQ_W-1:0] irq_clr;
  logic [frm_pkg::IRQ_W-1:0] irq_set;
  logic [frm_pkg::IRQ_W-1:0] next_irq_status;

  // named fields of the parity mask, used for readback
  logic dmem_b_bank3_mask;
  logic dmem_b_bank2_mask;
  logic dmem_b_bank1_mask;
  logic dmem_b_bank0_mask;
  logic dmem_a_bank3_mask;
  logic dmem_a_bank2_mask;
  logic dmem_a_bank1_mask;
  logic dmem_a_bank0_mask;
  logic progmem_1_mask;
  logic progmem_0_mask;
  logic rate_converter_1_mask;
  logic rate_converter_0_mask;

  // address decode, shared by read and write paths
  function automatic frm_pkg::frm_sel_type decode(input logic [frm_pkg::ADDR_W-1:0] addr);
    if (addr == frm_pkg::ADDR_CLEAR) begin
      decode = frm_pkg::SEL_CLEAR;
    end else if (addr == frm_pkg::ADDR_PAR_MASK) begin
      decode = frm_pkg::SEL_PAR_MASK;
    end else if (addr == frm_pkg::ADDR_SW_MASK) begin
      decode = frm_pkg::SEL_SW_MASK;
    end else if (addr == frm_pkg::ADDR_WD_MASK) begin
      decode = frm_pkg::SEL_WD_MASK;
    end else if (addr == frm_pkg::ADDR_FLAG) begin
      decode = frm_pkg::SEL_FLAG;
    end else if (addr == frm_pkg::ADDR_CODE) begin
      decode = frm_pkg::SEL_CODE;
    end else if (addr == frm_pkg::ADDR_IRQ_STATUS) begin
      decode = frm_pkg::SEL_IRQ_STATUS;
    end else if (addr == frm_pkg::ADDR_IRQ_CLEAR) begin
      decode = frm_pkg::SEL_IRQ_CLEAR;
    end else if (addr == frm_pkg::ADDR_IRQ_ENABLE) begin
      decode = frm_pkg::SEL_IRQ_ENABLE;
    end else begin
      decode = frm_pkg::SEL_NONE;
    end
  endfunction

  // byte-lane merge of write data into a 16-bit register image
  function automatic logic [frm_pkg::REG_W-1:0] merge(
    input logic [frm_pkg::REG_W-1:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0] strb
  );
    logic [frm_pkg::REG_W-1:0] res;
    res = old_val;
    if (strb[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wdata[15:8];
    end
    merge = res;
  endfunction

  // write strobe of one register; every storage process shares it
  function automatic logic wr_hit(
    input logic fire,
    input frm_pkg::frm_sel_type cur,
    input frm_pkg::frm_sel_type target
  );
    wr_hit = fire && (cur == target);
  endfunction

  assign sel = decode(PADDR);
  assign access = PSEL && PENABLE;
  // writes land only at the edge where pready is seen high
  assign wr_fire = access && PWRITE && (state == frm_pkg::ST_ACK);

  // merged images; only implemented bits are kept below
  assign wr_val_clear = merge({15'h0000, clear_bit}, PWDATA, PSTRB);
  assign wr_val_par = merge({4'h0, parity_mask}, PWDATA, PSTRB);
  assign wr_val_sw = merge({15'h0000, sw_mask}, PWDATA, PSTRB);
  assign wr_val_wd = merge({15'h0000, wd_mask}, PWDATA, PSTRB);
  assign wr_val_irq = merge(16'h0000, PWDATA, PSTRB);

  // second data memory banks
  assign dmem_b_bank3_mask = parity_mask[frm_pkg::POS_DMEM_B_BANK3];
  assign dmem_b_bank2_mask = parity_mask[frm_pkg::POS_DMEM_B_BANK2];
  assign dmem_b_bank1_mask = parity_mask[frm_pkg::POS_DMEM_B_BANK1];
  assign dmem_b_bank0_mask = parity_mask[frm_pkg::POS_DMEM_B_BANK0];

  // first data memory banks
  assign dmem_a_bank3_mask = parity_mask[frm_pkg::POS_DMEM_A_BANK3];
  assign dmem_a_bank2_mask = parity_mask[frm_pkg::POS_DMEM_A_BANK2];
  assign dmem_a_bank1_mask = parity_mask[frm_pkg::POS_DMEM_A_BANK1];
  assign dmem_a_bank0_mask = parity_mask[frm_pkg::POS_DMEM_A_BANK0];

  // program memories and rate converters; converters masked after reset
  assign progmem_1_mask = parity_mask[frm_pkg::POS_PROGMEM_1];
  assign progmem_0_mask = parity_mask[frm_pkg::POS_PROGMEM_0];
  assign rate_converter_1_mask = parity_mask[frm_pkg::POS_RATE_CONVERTER_1];
  assign rate_converter_0_mask = parity_mask[frm_pkg::POS_RATE_CONVERTER_0];

  // apb handshake: one wait state so read data comes from a flop
  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= frm_pkg::ST_IDLE;
      PREADY <= 1'b0;
    end else begin
      case (state)
        frm_pkg::ST_IDLE: begin
          if (access) begin
            state <= frm_pkg::ST_ACK;
            PREADY <= 1'b1;
          end
        end
        frm_pkg::ST_ACK: begin
          state <= frm_pkg::ST_IDLE;
          PREADY <= 1'b0;
        end
        default: begin
          state <= frm_pkg::ST_IDLE;
          PREADY <= 1'b0;
        end
      endcase
    end
  end

  // read mux; reserved bits read zero
  always_comb begin
    rd_val = 16'h0000;
    if (sel == frm_pkg::SEL_CLEAR) begin
      rd_val[frm_pkg::CLEAR_POS] = clear_bit;
    end else if (sel == frm_pkg::SEL_PAR_MASK) begin
      rd_val[frm_pkg::POS_DMEM_B_BANK3] = dmem_b_bank3_mask;
      rd_val[frm_pkg::POS_DMEM_B_BANK2] = dmem_b_bank2_mask;
      rd_val[frm_pkg::POS_DMEM_B_BANK1] = dmem_b_bank1_mask;
      rd_val[frm_pkg::POS_DMEM_B_BANK0] = dmem_b_bank0_mask;
      rd_val[frm_pkg::POS_DMEM_A_BANK3] = dmem_a_bank3_mask;
      rd_val[frm_pkg::POS_DMEM_A_BANK2] = dmem_a_bank2_mask;
      rd_val[frm_pkg::POS_DMEM_A_BANK1] = dmem_a_bank1_mask;
      rd_val[frm_pkg::POS_DMEM_A_BANK0] = dmem_a_bank0_mask;
      rd_val[frm_pkg::POS_PROGMEM_1] = progmem_1_mask;
      rd_val[frm_pkg::POS_PROGMEM_0] = progmem_0_mask;
      rd_val[frm_pkg::POS_RATE_CONVERTER_1] = rate_converter_1_mask;
      rd_val[frm_pkg::POS_RATE_CONVERTER_0] = rate_converter_0_mask;
    end else if (sel == frm_pkg::SEL_SW_MASK) begin
      rd_val[frm_pkg::SW_MASK_POS] = sw_mask;
    end else if (sel == frm_pkg::SEL_WD_MASK) begin
      rd_val[frm_pkg::WD_MASK_POS] = wd_mask;
    end else if (sel == frm_pkg::SEL_FLAG) begin
      rd_val[frm_pkg::FLAG_POS] = fault_flag;
    end else if (sel == frm_pkg::SEL_CODE) begin
      rd_val = fault_code;
    end else if (sel == frm_pkg::SEL_IRQ_STATUS) begin
      rd_val[frm_pkg::IRQ_W-1:0] = irq_status;
    end else if (sel == frm_pkg::SEL_IRQ_ENABLE) begin
      rd_val[frm_pkg::IRQ_W-1:0] = irq_enable;
    end else begin
      rd_val = 16'h0000;
    end
  end

  // read data captured in the first access cycle, held for the ack
  always_ff @(posedge CLK) begin
    if (RST) begin
      PRDATA <= 32'h00000000;
    end else if (access && state == frm_pkg::ST_IDLE) begin
      PRDATA <= PWRITE ? 32'h00000000 : {16'h0000, rd_val};
    end else if (state == frm_pkg::ST_ACK) begin
      PRDATA <= 32'h00000000;
    end
  end

  // unmapped addresses answer with an error, reads and writes alike
  always_ff @(posedge CLK) begin
    if (RST) begin
      PSLVERR <= 1'b0;
    end else if (access && state == frm_pkg::ST_IDLE) begin
      PSLVERR <= (sel == frm_pkg::SEL_NONE);
    end else if (state == frm_pkg::ST_ACK) begin
      PSLVERR <= 1'b0;
    end
  end

  // clear bit storage; reserved bits of the word are dropped
  always_ff @(posedge CLK) begin
    if (RST) begin
      clear_bit <= frm_pkg::RST_CLEAR;
    end else if (wr_hit(wr_fire, sel, frm_pkg::SEL_CLEAR)) begin
      clear_bit <= wr_val_clear[frm_pkg::CLEAR_POS];
    end
  end

  // rising-edge detector on the clear bit, one-cycle pulse
  always_ff @(posedge CLK) begin
    if (RST) begin
      clear_pulse <= 1'b0;
    end else if (wr_hit(wr_fire, sel, frm_pkg::SEL_CLEAR)) begin
      // writing one over one, or zero, leaves the fault state alone
      clear_pulse <= wr_val_clear[frm_pkg::CLEAR_POS] && !clear_bit;
    end else begin
      clear_pulse <= 1'b0;
    end
  end

  // parity mask, reserved upper bits are never stored
  always_ff @(posedge CLK) begin
    if (RST) begin
      parity_mask <= frm_pkg::RST_PAR_MASK;
    end else if (wr_hit(wr_fire, sel, frm_pkg::SEL_PAR_MASK)) begin
      parity_mask <= wr_val_par[frm_pkg::PAR_W-1:0];
    end
  end

  // software mask bit
  always_ff @(posedge CLK) begin
    if (RST) begin
      sw_mask <= frm_pkg::RST_SW_MASK;
    end else if (wr_hit(wr_fire, sel, frm_pkg::SEL_SW_MASK)) begin
      sw_mask <= wr_val_sw[frm_pkg::SW_MASK_POS];
    end
  end

  // watchdog mask bit
  always_ff @(posedge CLK) begin
    if (RST) begin
      wd_mask <= frm_pkg::RST_WD_MASK;
    end else if (wr_hit(wr_fire, sel, frm_pkg::SEL_WD_MASK)) begin
      wd_mask <= wr_val_wd[frm_pkg::WD_MASK_POS];
    end
  end

  // masking, sticky flag and first-error capture
  frm_fault_capture u_capture (
    .clk(CLK),
    .rst(RST),
    .parity_err(PARITY_ERR),
    .sw_err(SW_ERR),
    .wd_err(WD_ERR),
    .parity_mask(parity_mask),
    .sw_mask(sw_mask),
    .wd_mask(wd_mask),
    .clear_pulse(clear_pulse),
    .fault_flag(fault_flag),
    .fault_code(fault_code),
    .first_event(first_event),
    .later_event(later_event)
  );

  // interrupt status: write-one-to-clear, a new event wins over the clear
  always_comb begin
    irq_set = '0;
    irq_set[frm_pkg::IRQ_FIRST_POS] = first_event;
    irq_set[frm_pkg::IRQ_LATER_POS] = later_event;
    irq_clr = '0;
    if (wr_hit(wr_fire, sel, frm_pkg::SEL_IRQ_CLEAR)) begin
      irq_clr = wr_val_irq[frm_pkg::IRQ_W-1:0];
    end
    next_irq_status = (irq_status & ~irq_clr) | irq_set;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_status <= frm_pkg::RST_IRQ;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // interrupt enable
  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_enable <= frm_pkg::RST_IRQ;
    end else if (wr_hit(wr_fire, sel, frm_pkg::SEL_IRQ_ENABLE)) begin
      irq_enable <= wr_val_irq[frm_pkg::IRQ_W-1:0];
    end
  end

  // interrupt pin straight from a flop; lags the status by one cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_status & irq_enable);
    end
  end

  // fault pin, a registered copy of the internal flag
  always_ff @(posedge CLK) begin
    if (RST) begin
      FAULT <= 1'b0;
    end else begin
      FAULT <= fault_flag;
    end
  end

endmodule // frm_fault_report

// file: verification/frm_fault_report_checker.sv
`timescale 1ns/1ns
module frm_fault_report_checker (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [frm_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [frm_pkg::PAR_W-1:0] PARITY_ERR,
  input wire logic SW_ERR,
  input wire logic WD_ERR,
  input wire logic FAULT,
  input wire logic IRQ
);
  int since_clr;
  wire any_err = SW_ERR || WD_ERR || (|PARITY_ERR);
  // age of the last clear write; saturates so it never wraps into a false match
  always_ff @(posedge CLK) begin
    if (RST || (PSEL && PENABLE && PREADY && PWRITE && PADDR == frm_pkg::ADDR_CLEAR
        && PWDATA[0] && PSTRB[0]))
      since_clr <= 0;
    else if (since_clr < 15)
      since_clr <= since_clr + 1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_access;
    PSEL && PENABLE && !PREADY;
  endsequence
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held too long");
  a_ready_wait: assert property (s_access |=> PREADY) else $error("no ready after access");
  a_err_unmapped: assert property (s_access ##0 PADDR[17:16] != 2'b11 |=> PSLVERR)
    else $error("unmapped access without error");
  a_err_mapped: assert property (s_access ##0 PADDR == frm_pkg::ADDR_PAR_MASK |=> !PSLVERR)
    else $error("mapped access flagged");
  a_rdata_quiet: assert property (!PREADY |-> PRDATA == 32'h00000000) else $error("stray rdata");
  a_reserved_zero: assert property (PREADY |-> PRDATA[31:16] == 16'h0000)
    else $error("upper read bits set");
  // the flag takes the error at one edge, the pin follows one edge later
  a_fault_cause: assert property ($rose(FAULT) |-> $past(any_err, 2))
    else $error("fault rose without error");
  a_fault_sticky: assert property ($fell(FAULT) |-> since_clr <= 6)
    else $error("fault dropped without clear");
endmodule // frm_fault_report_checker

bind frm_fault_report frm_fault_report_checker frm_fault_report_checker_i (
  .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .PARITY_ERR(PARITY_ERR), .SW_ERR(SW_ERR), .WD_ERR(WD_ERR), .FAULT(FAULT), .IRQ(IRQ));

// file: verification/frm_fault_report_tb.sv
`timescale 1ns/1ns
module frm_fault_report_tb;
  logic CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [17:0] PADDR = 18'h00000;
  logic [31:0] PWDATA = 32'h00000000, PRDATA;
  logic [3:0] PSTRB = 4'hF;
  logic [11:0] PARITY_ERR = 12'h000;
  logic SW_ERR = 1'b0, WD_ERR = 1'b0, PREADY, PSLVERR, FAULT, IRQ;
  int fail_count = 0, n_checks = 0, cycles = 0;
  frm_fault_report frm_fault_report_i (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PARITY_ERR(PARITY_ERR), .SW_ERR(SW_ERR),
    .WD_ERR(WD_ERR), .FAULT(FAULT), .IRQ(IRQ));
  // 125 MHz core clock
  initial begin
    forever #4 CLK = ~CLK;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // a hung handshake ends here rather than running forever
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      final_report;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  // one apb transfer; values read right after the edge are the pre-edge samples
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [17:0] a, input logic [15:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, {16'h0000, d}, rd, er);
    chk("write error", 32'h0, {31'h0, er});
  endtask
  task automatic rdchk(input string what, input logic [17:0] a, input logic [15:0] exp);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0, rd, er);
    chk(what, {16'h0000, exp}, rd);
  endtask
  // code layout: parity 11..0, watchdog 12, software 15
  task automatic set_mask(input logic [15:0] m);
    wr(frm_pkg::ADDR_PAR_MASK, {4'h0, m[11:0]});
    wr(frm_pkg::ADDR_WD_MASK, {15'h0, m[12]});
    wr(frm_pkg::ADDR_SW_MASK, {15'h0, m[15]});
  endtask
  task automatic raise(input logic [15:0] c);
    @(posedge CLK);
    PARITY_ERR <= c[11:0];
    WD_ERR <= c[12];
    SW_ERR <= c[15];
    @(posedge CLK);
    PARITY_ERR <= 12'h000;
    WD_ERR <= 1'b0;
    SW_ERR <= 1'b0;
    repeat (3) @(posedge CLK);
  endtask
  task automatic t_reset;
    rdchk("clear", frm_pkg::ADDR_CLEAR, 16'h0000);
    rdchk("par mask", frm_pkg::ADDR_PAR_MASK, 16'h0003);
    rdchk("sw mask", frm_pkg::ADDR_SW_MASK, 16'h0000);
    rdchk("wd mask", frm_pkg::ADDR_WD_MASK, 16'h0000);
    rdchk("flag", frm_pkg::ADDR_FLAG, 16'h0000);
  endtask
  task automatic t_reserved;
    logic [31:0] rd;
    logic er;
    wr(frm_pkg::ADDR_PAR_MASK, 16'hFFFF);
    rdchk("par mask", frm_pkg::ADDR_PAR_MASK, 16'h0FFF);
    // upper byte lane only: bits 11..8 follow the data, 7..0 keep their value
    PSTRB <= 4'h2;
    wr(frm_pkg::ADDR_PAR_MASK, 16'h0000);
    PSTRB <= 4'hF;
    rdchk("par mask lane", frm_pkg::ADDR_PAR_MASK, 16'h00FF);
    wr(frm_pkg::ADDR_SW_MASK, 16'hFFFE);
    rdchk("sw mask", frm_pkg::ADDR_SW_MASK, 16'h0000);
    wr(frm_pkg::ADDR_CLEAR, 16'hFFFE);
    rdchk("clear", frm_pkg::ADDR_CLEAR, 16'h0000);
    apb(1'b0, 18'h00010, 32'h0, rd, er);
    chk("unmapped error", 32'h1, {31'h0, er});
  endtask
  // every source alone: masked it is silent, unmasked it sets flag and code
  task automatic t_sources;
    logic [15:0] c;
    for (int i = 0; i < 16; i++) begin
      if (i == 13 || i == 14)
        continue;
      c = 16'h0001 << i;
      set_mask(c);
      raise(c);
      chk("masked fault", 32'h0, {31'h0, FAULT});
      set_mask(16'h0000);
      raise(c);
      chk("fault", 32'h1, {31'h0, FAULT});
      rdchk("code", frm_pkg::ADDR_CODE, c);
      wr(frm_pkg::ADDR_CLEAR, 16'h0001);
      wr(frm_pkg::ADDR_CLEAR, 16'h0000);
      repeat (3) @(posedge CLK);
      chk("cleared", 32'h0, {31'h0, FAULT});
      rdchk("code cleared", frm_pkg::ADDR_CODE, 16'h0000);
    end
  endtask
  task automatic t_first_irq;
    raise(16'h0010);
    raise(16'h1000);
    rdchk("first code", frm_pkg::ADDR_CODE, 16'h0010);
    chk("sticky", 32'h1, {31'h0, FAULT});
    rdchk("irq status", frm_pkg::ADDR_IRQ_STATUS, 16'h0003);
    chk("irq masked", 32'h0, {31'h0, IRQ});
    wr(frm_pkg::ADDR_IRQ_ENABLE, 16'h0003);
    repeat (3) @(posedge CLK);
    chk("irq on", 32'h1, {31'h0, IRQ});
    wr(frm_pkg::ADDR_IRQ_CLEAR, 16'h0003);
    repeat (3) @(posedge CLK);
    chk("irq off", 32'h0, {31'h0, IRQ});
    rdchk("irq status", frm_pkg::ADDR_IRQ_STATUS, 16'h0000);
  endtask
  // a repeated one or a falling write must not clear
  task automatic t_clear_edge;
    wr(frm_pkg::ADDR_CLEAR, 16'h0001);
    repeat (3) @(posedge CLK);
    chk("clear rise", 32'h0, {31'h0, FAULT});
    raise(16'h0010);
    wr(frm_pkg::ADDR_CLEAR, 16'h0001);
    repeat (3) @(posedge CLK);
    chk("held one", 32'h1, {31'h0, FAULT});
    wr(frm_pkg::ADDR_CLEAR, 16'h0000);
    repeat (3) @(posedge CLK);
    chk("clear fall", 32'h1, {31'h0, FAULT});
    wr(frm_pkg::ADDR_CLEAR, 16'h0001);
    repeat (3) @(posedge CLK);
    chk("clear again", 32'h0, {31'h0, FAULT});
  endtask
  // reset in mid-run: flag, code, clear bit and parity mask return to reset values
  task automatic t_mid_reset;
    wr(frm_pkg::ADDR_PAR_MASK, 16'h0FF0);
    raise(16'h0001);
    chk("fault before reset", 32'h1, {31'h0, FAULT});
    RST <= 1'b1;
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    chk("fault after reset", 32'h0, {31'h0, FAULT});
    chk("irq after reset", 32'h0, {31'h0, IRQ});
    rdchk("flag reset", frm_pkg::ADDR_FLAG, 16'h0000);
    rdchk("code reset", frm_pkg::ADDR_CODE, 16'h0000);
    rdchk("clear reset", frm_pkg::ADDR_CLEAR, 16'h0000);
    rdchk("par mask reset", frm_pkg::ADDR_PAR_MASK, 16'h0003);
  endtask
  initial begin
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    t_reset;
    t_reserved;
    t_sources;
    t_first_irq;
    t_clear_edge;
    t_mid_reset;
    final_report;
  end
endmodule // frm_fault_report_tb
